// ---- rtl/ecw_defs.vh ----
// register offsets, field positions and reset values for the interrupt and wake block
`ifndef ECW_DEFS_VH
`define ECW_DEFS_VH

// register byte offsets
`define ECW_OFF_FLAG 8'h00
`define ECW_OFF_ENABLE 8'h04
`define ECW_OFF_CTRL 8'h08
`define ECW_OFF_STAT 8'h0C
`define ECW_OFF_PHY_EN 8'h10
`define ECW_OFF_PHY_REQ 8'h14
`define ECW_OFF_WAKE_EN 8'h18
`define ECW_OFF_WAKE_REQ 8'h1C
`define ECW_OFF_PKT_CNT 8'h20
`define ECW_OFF_PKT_DEC 8'h24
`define ECW_OFF_FLAG_CLR 8'h28
`define ECW_OFF_WAKE_CLR 8'h2C

// flag and enable register fields
`define ECW_B_TX 3
`define ECW_B_LINK 4
`define ECW_B_DMA 5
`define ECW_B_PKT 6
`define ECW_B_WAKE 2
`define ECW_B_GLOBAL 7

// control register fields
`define ECW_B_TXREQ 3
`define ECW_B_DMA_START_BIT 5

// status register fields
`define ECW_B_TX_ABORT_STATUS 1
`define ECW_B_LATCHED_LINK_STATUS 2

// phy enable and request fields
`define ECW_B_PHY_LINK_ENABLE 4
`define ECW_B_PHY_GLOBAL_ENABLE 1
`define ECW_B_PHY_LINK_FLAG 4
`define ECW_B_PHY_GLOBAL_FLAG 2

// wake condition field layout
`define ECW_WAKE_W 8
`define ECW_WAKE_MASK 8'hDF

`define ECW_RST_ZERO 32'h00000000
`define ECW_PKT_W 8

`endif

// ---- rtl/ecw_sticky.v ----
// one sticky flag where a set in the same cycle beats a clear
`timescale 1ns/10ps
module ecw_sticky (
	input wire aclk, // clock
	input wire aresetn, // synchronous reset, active low
	input wire set_i, // set event
	input wire clr_i, // clear request
	output reg flag_r // flag
);
	// set wins over clear so no event is lost
	always @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 1'b0;
		end else if (set_i) begin
			flag_r <= 1'b1;
		end else if (clr_i) begin
			flag_r <= 1'b0;
		end
	end
endmodule

// ---- rtl/ecw_irq_wake.v ----
// interrupt flags, enables and wake logic behind an axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "ecw_defs.vh"

// Notes on behaviour
// - tx done set on request falling edge
// - tx, dma flags stay until cleared; link flag drops with phy enables
// - irq pin needs source and global enable
// - flags set regardless of main enables
// - no link flag before phy enables
// - link flag mirrors phy global flag
// - link irq needs all four enables
// - link flag read-only, phy read clears
// - dma done set on start falling edge
// - host abort of dma sets done
// - packet pending while counter non-zero
// - packet irq on each new packet
// - counter decremented to zero clears pending
// - wake pin ignores global irq enable
// - seven wake conditions, each enabled
// - only receive-filter passed packets wake
// - wake request flag set regardless enable
// - summary wake needs condition enable
// - wake pin low with summary and enable
// - aborted packets never wake
// - phy link flag set on change, read clears
module ecw_irq_wake #(
	parameter PKT_W = `ECW_PKT_W, // packet counter width
	parameter WAKE_W = `ECW_WAKE_W // wake condition vector width
) (
	input wire aclk, // clock
	input wire aresetn, // synchronous reset, active low
	input wire [7:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output wire s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write strobes
	input wire s_axi_wvalid, // write data valid
	output wire s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [7:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output wire s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire tx_done_i, // transmit finished, clears request
	input wire tx_abort_i, // transmit aborted, clears request
	input wire dma_done_i, // dma finished, clears start bit
	input wire live_link_status, // link level from the phy
	input wire rx_pkt_ok_i, // packet written, passed receive filters
	input wire rx_pkt_abort_i, // packet aborted, not stored
	input wire [WAKE_W-1:0] wake_match_i, // wake conditions met by this packet
	output wire tx_request_bit, // transmit requested
	output wire dma_start_bit, // dma running
	output reg int_n, // main interrupt pin, active low
	output reg wake_pin_n // wake pin, active low
);
	localparam [1:0] RESP_OK = 2'b00;
	localparam [1:0] RESP_ERR = 2'b10;

	reg [7:0] main_enable_register_r;
	reg [7:0] ctrl_r;
	reg tx_abort_status_r;
	reg [7:0] phy_irq_enable_register_r;
	reg [WAKE_W-1:0] wake_enable_register_r;
	reg [PKT_W-1:0] rx_packet_counter_r;
	reg [PKT_W-1:0] pkt_cnt_nxt;
	reg link_seen_r;
	reg link_hist_r;
	reg phy_link_flag_r;
	reg txreq_d_r;
	reg dma_start_bit_d_r;
	reg pkt_pulse_r;
	reg aw_held_r;
	reg w_held_r;
	reg [7:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [31:0] rd_nxt;
	reg rd_err;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire wr_fire;
	wire rd_fire;
	wire tx_done_flag;
	wire dma_done_flag;
	wire summary_wake_flag;
	wire [WAKE_W-1:0] wake_request_register;
	wire packet_pending_flag;
	wire link_change_flag;
	wire phy_global_flag;
	wire phy_req_read;
	wire phy_armed;
	wire gie;
	wire [WAKE_W-1:0] wake_hit;
	wire [WAKE_W-1:0] wake_clr;
	wire [7:0] flag_view;

	// write channels taken in either order, one write in flight
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
	assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
	assign wr_fire = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
		(w_held_r || (s_axi_wvalid && s_axi_wready));
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// only the low byte lane carries register bits
	reg s_axi_wstrb_held_r;
	wire s_axi_wstrb_q = w_held_r ? s_axi_wstrb_held_r : s_axi_wstrb[0];
	wire wb0 = wr_fire && s_axi_wstrb_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= `ECW_RST_ZERO;
			s_axi_wstrb_held_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
		end else begin
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr > `ECW_OFF_WAKE_CLR || wr_addr[1:0] != 2'b00) ?
					RESP_ERR : RESP_OK;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_r <= 1'b1;
					aw_addr_r <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_r <= 1'b1;
					w_data_r <= s_axi_wdata;
					s_axi_wstrb_held_r <= s_axi_wstrb[0];
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// write decode strobes
	wire wr_en = wb0 && wr_addr == `ECW_OFF_ENABLE;
	wire wr_ctrl = wb0 && wr_addr == `ECW_OFF_CTRL;
	wire wr_stat = wb0 && wr_addr == `ECW_OFF_STAT;
	wire wr_phy_en = wb0 && wr_addr == `ECW_OFF_PHY_EN;
	wire wr_wake_en = wb0 && wr_addr == `ECW_OFF_WAKE_EN;
	wire wr_pkt_dec = wb0 && wr_addr == `ECW_OFF_PKT_DEC;
	wire wr_flag_clr = wb0 && wr_addr == `ECW_OFF_FLAG_CLR;
	wire wr_wake_clr = wb0 && wr_addr == `ECW_OFF_WAKE_CLR;
	wire [7:0] fclr = wr_flag_clr ? wr_data[7:0] : 8'h00;

	// control register: host sets request bits, hardware clears them on completion or tx abort
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= 8'h00;
			tx_abort_status_r <= 1'b0;
			main_enable_register_r <= 8'h00;
			phy_irq_enable_register_r <= 8'h00;
			wake_enable_register_r <= {WAKE_W{1'b0}};
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= wr_data[7:0];
			end else begin
				if (tx_done_i || tx_abort_i) begin
					ctrl_r[`ECW_B_TXREQ] <= 1'b0;
				end
				if (dma_done_i) begin
					ctrl_r[`ECW_B_DMA_START_BIT] <= 1'b0;
				end
			end
			// abort status for the host's success test
			if (tx_abort_i && tx_request_bit) begin
				tx_abort_status_r <= 1'b1;
			end else if (wr_stat && !wr_data[`ECW_B_TX_ABORT_STATUS]) begin
				tx_abort_status_r <= 1'b0;
			end
			if (wr_en) begin
				main_enable_register_r <= wr_data[7:0];
			end
			if (wr_phy_en) begin
				phy_irq_enable_register_r <= wr_data[7:0] & 8'h12;
			end
			if (wr_wake_en) begin
				wake_enable_register_r <= wr_data[WAKE_W-1:0] & `ECW_WAKE_MASK;
			end
		end
	end
	assign tx_request_bit = ctrl_r[`ECW_B_TXREQ];
	assign dma_start_bit = ctrl_r[`ECW_B_DMA_START_BIT];

	// edge history for falling-edge detection of request bits
	always @(posedge aclk) begin
		if (!aresetn) begin
			txreq_d_r <= 1'b0;
			dma_start_bit_d_r <= 1'b0;
		end else begin
			txreq_d_r <= tx_request_bit;
			dma_start_bit_d_r <= dma_start_bit;
		end
	end

	// any fall counts: completion, abort or host cancel
	ecw_sticky u_tx (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_i(txreq_d_r && !tx_request_bit),
		.clr_i(fclr[`ECW_B_TX]),
		.flag_r(tx_done_flag)
	);

	// host clearing start also lands here as a fall
	ecw_sticky u_dma (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_i(dma_start_bit_d_r && !dma_start_bit),
		.clr_i(fclr[`ECW_B_DMA]),
		.flag_r(dma_done_flag)
	);

	// phy link change flag: set on level change, cleared by a read of the request register
	assign phy_req_read = rd_fire && s_axi_araddr == `ECW_OFF_PHY_REQ;
	always @(posedge aclk) begin
		if (!aresetn) begin
			link_seen_r <= 1'b0;
			link_hist_r <= 1'b0;
			phy_link_flag_r <= 1'b0;
		end else begin
			link_seen_r <= live_link_status;
			link_hist_r <= 1'b1;
			// no history in the first cycle after reset, so a link already up is no change
			if (link_hist_r && link_seen_r != live_link_status) begin
				phy_link_flag_r <= 1'b1;
			end else if (phy_req_read) begin
				phy_link_flag_r <= 1'b0;
			end
		end
	end
	// one phy source only, so global flag is the link flag gated by both phy enables
	assign phy_armed = phy_irq_enable_register_r[`ECW_B_PHY_LINK_ENABLE] &&
		phy_irq_enable_register_r[`ECW_B_PHY_GLOBAL_ENABLE];
	assign phy_global_flag = phy_link_flag_r && phy_armed;
	assign link_change_flag = phy_global_flag;

	// counter of packets held in the receive buffer
	always @* begin
		pkt_cnt_nxt = rx_packet_counter_r;
		if (rx_pkt_ok_i && !(&rx_packet_counter_r)) begin
			pkt_cnt_nxt = pkt_cnt_nxt + 1'b1;
		end
		if (wr_pkt_dec && wr_data[0] && pkt_cnt_nxt != {PKT_W{1'b0}}) begin
			pkt_cnt_nxt = pkt_cnt_nxt - 1'b1;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_packet_counter_r <= {PKT_W{1'b0}};
			pkt_pulse_r <= 1'b0;
		end else begin
			rx_packet_counter_r <= pkt_cnt_nxt;
			pkt_pulse_r <= rx_pkt_ok_i;
		end
	end
	assign packet_pending_flag = rx_packet_counter_r != {PKT_W{1'b0}};

	// wake flags: only stored, filter-passed packets count
	assign wake_hit = (rx_pkt_ok_i && !rx_pkt_abort_i) ?
		(wake_match_i & `ECW_WAKE_MASK) : {WAKE_W{1'b0}};
	assign wake_clr = wr_wake_clr ? wr_data[WAKE_W-1:0] : {WAKE_W{1'b0}};
	genvar gi;
	generate
		for (gi = 0; gi < WAKE_W; gi = gi + 1) begin : g_wake
			ecw_sticky u_wk (
				.aclk(aclk),
				.aresetn(aresetn),
				.set_i(wake_hit[gi]),
				.clr_i(wake_clr[gi]),
				.flag_r(wake_request_register[gi])
			);
		end
	endgenerate
	ecw_sticky u_wsum (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_i(|(wake_hit & wake_enable_register_r)),
		.clr_i(fclr[`ECW_B_WAKE]),
		.flag_r(summary_wake_flag)
	);

	assign flag_view = {1'b0, packet_pending_flag, dma_done_flag, link_change_flag,
		tx_done_flag, summary_wake_flag, 2'b00};
	assign gie = main_enable_register_r[`ECW_B_GLOBAL];

	// pins: registered, low while any enabled flag stands
	always @(posedge aclk) begin
		if (!aresetn) begin
			int_n <= 1'b1;
			wake_pin_n <= 1'b1;
		end else begin
			int_n <= !(gie && (
				(tx_done_flag && main_enable_register_r[`ECW_B_TX]) ||
				(dma_done_flag && main_enable_register_r[`ECW_B_DMA]) ||
				(link_change_flag && main_enable_register_r[`ECW_B_LINK]) ||
				((packet_pending_flag || pkt_pulse_r) && main_enable_register_r[`ECW_B_PKT])));
			// wake pin does not look at the global interrupt enable
			wake_pin_n <= !(summary_wake_flag && main_enable_register_r[`ECW_B_WAKE]);
		end
	end

	// read mux
	always @* begin
		rd_nxt = `ECW_RST_ZERO;
		rd_err = 1'b0;
		case (s_axi_araddr)
			`ECW_OFF_FLAG: rd_nxt[7:0] = flag_view;
			`ECW_OFF_ENABLE: rd_nxt[7:0] = main_enable_register_r;
			`ECW_OFF_CTRL: rd_nxt[7:0] = ctrl_r;
			`ECW_OFF_STAT: begin
				rd_nxt[`ECW_B_TX_ABORT_STATUS] = tx_abort_status_r;
				rd_nxt[`ECW_B_LATCHED_LINK_STATUS] = live_link_status;
			end
			`ECW_OFF_PHY_EN: rd_nxt[7:0] = phy_irq_enable_register_r;
			`ECW_OFF_PHY_REQ: begin
				rd_nxt[`ECW_B_PHY_LINK_FLAG] = phy_link_flag_r;
				rd_nxt[`ECW_B_PHY_GLOBAL_FLAG] = phy_global_flag;
			end
			`ECW_OFF_WAKE_EN: rd_nxt[WAKE_W-1:0] = wake_enable_register_r;
			`ECW_OFF_WAKE_REQ: rd_nxt[WAKE_W-1:0] = wake_request_register;
			`ECW_OFF_PKT_CNT: rd_nxt[PKT_W-1:0] = rx_packet_counter_r;
			`ECW_OFF_PKT_DEC: rd_nxt = `ECW_RST_ZERO;
			`ECW_OFF_FLAG_CLR: rd_nxt = `ECW_RST_ZERO;
			`ECW_OFF_WAKE_CLR: rd_nxt = `ECW_RST_ZERO;
			default: rd_err = 1'b1;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `ECW_RST_ZERO;
			s_axi_rresp <= RESP_OK;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_nxt;
			s_axi_rresp <= rd_err ? RESP_ERR : RESP_OK;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ---- sim/ecw_irq_wake_checker.sv ----
// port assertions for the interrupt and wake block
`timescale 1ns/10ps
module ecw_irq_wake_checker (
	input wire aclk, // clock
	input wire aresetn, // reset, low
	input wire s_axi_awvalid, // aw valid
	input wire s_axi_awready, // aw ready
	input wire s_axi_wvalid, // w valid
	input wire s_axi_wready, // w ready
	input wire s_axi_bvalid, // b valid
	input wire s_axi_bready, // b ready
	input wire s_axi_arvalid, // ar valid
	input wire s_axi_arready, // ar ready
	input wire s_axi_rvalid, // r valid
	input wire s_axi_rready, // r ready
	input wire tx_done_i, // tx end
	input wire dma_done_i, // dma end
	input wire rx_pkt_ok_i, // packet stored
	input wire tx_request_bit, // tx request
	input wire dma_start_bit, // dma running
	input wire int_n, // irq pin
	input wire wake_pin_n // wake pin
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// reset is the cause here, so it must not disable this one
	a_reset_idle: assert property (disable iff (1'h0) !aresetn |=> int_n && wake_pin_n)
		else $error("pins active after reset");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |-> !s_axi_awready
		##1 !s_axi_bvalid) else $error("write response misbehaves");
	a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |-> !s_axi_arready
		##1 !s_axi_rvalid) else $error("read response misbehaves");
	// a write in the same cycle may set the bit again, set wins
	a_tx_req_drop: assert property (tx_done_i && !s_axi_wvalid |=> !tx_request_bit)
		else $error("tx request not cleared");
	a_dma_start_drop: assert property (dma_done_i && !s_axi_wvalid |=> !dma_start_bit)
		else $error("dma start not cleared");
	// wake pin edge needs a stored packet or an enable write shortly before
	a_wake_cause: assert property ($fell(wake_pin_n) |-> $past(rx_pkt_ok_i, 2)
		|| $past(rx_pkt_ok_i, 3) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
		else $error("wake pin fell without cause");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_irq: cover property ($fell(int_n));
	c_wake: cover property ($fell(wake_pin_n));
endmodule

bind ecw_irq_wake ecw_irq_wake_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .tx_done_i,
	.dma_done_i, .rx_pkt_ok_i, .tx_request_bit, .dma_start_bit, .int_n, .wake_pin_n);

// ---- sim/ecw_host.sv ----
// host model: axi4-lite master with one write and one read task
`timescale 1ns/10ps
module ecw_host (
	input wire aclk, // clock
	output reg [7:0] awaddr = 8'h00, // aw addr
	output reg awvalid = 1'h0, // aw valid
	input wire awready, // aw ready
	output reg [31:0] wdata = 32'h0, // w data
	output wire [3:0] wstrb, // w strobes
	output reg wvalid = 1'h0, // w valid
	input wire wready, // w ready
	input wire [1:0] bresp, // b resp
	input wire bvalid, // b valid
	output reg bready = 1'h0, // b ready
	output reg [7:0] araddr = 8'h00, // ar addr
	output reg arvalid = 1'h0, // ar valid
	input wire arready, // ar ready
	input wire [31:0] rdata, // r data
	input wire [1:0] rresp, // r resp
	input wire rvalid, // r valid
	output reg rready = 1'h0 // r ready
);
	assign wstrb = 4'hF;
	// address and data go out together, each dropped once taken
	task wr(input [7:0] a, input [31:0] v, output [1:0] r);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			do begin
				@(posedge aclk);
				if (awready) awvalid <= 1'h0;
				if (wready) wvalid <= 1'h0;
			end while (bvalid !== 1'h1);
			r = bresp;
			bready <= 1'h0;
		end
	endtask
	task rd(input [7:0] a, output [31:0] v, output [1:0] r);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
			do begin
				@(posedge aclk);
				if (arready) arvalid <= 1'h0;
			end while (rvalid !== 1'h1);
			v = rdata;
			r = rresp;
			rready <= 1'h0;
		end
	endtask
endmodule

// ---- sim/test_ecw_irq_wake.sv ----
// bench for the interrupt and wake block, register tests over axi4-lite
`timescale 1ns/10ps
`include "ecw_defs.vh"
module test_ecw_irq_wake;
	localparam [7:0] FLG = `ECW_OFF_FLAG, ENA = `ECW_OFF_ENABLE, CTL = `ECW_OFF_CTRL;
	localparam [7:0] STA = `ECW_OFF_STAT, PEN = `ECW_OFF_PHY_EN, PRQ = `ECW_OFF_PHY_REQ;
	localparam [7:0] WEN = `ECW_OFF_WAKE_EN, WRQ = `ECW_OFF_WAKE_REQ, CNT = `ECW_OFF_PKT_CNT;
	localparam [7:0] DEC = `ECW_OFF_PKT_DEC, FCL = `ECW_OFF_FLAG_CLR, WCL = `ECW_OFF_WAKE_CLR;
	reg aclk = 1'h0;
	reg aresetn = 1'h0;
	reg [4:0] ev = 5'h00; // tx abort, pkt abort, pkt stored, dma end, tx end
	reg [7:0] wm = 8'h00;
	reg lnk = 1'h0;
	wire [7:0] awaddr, araddr;
	wire [31:0] wdata, rdata;
	wire [3:0] wstrb;
	wire [1:0] bresp, rresp;
	wire awvalid, awready, wvalid, wready, bvalid, bready;
	wire arvalid, arready, rvalid, rready, int_n, wake_pin_n;
	reg [31:0] d;
	reg [1:0] r;
	integer err_total = 0;
	integer n_checks = 0;
	integer i;
	ecw_host u_ecw_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	ecw_irq_wake u_ecw_irq_wake (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tx_done_i(ev[0]), .tx_abort_i(ev[4]), .dma_done_i(ev[1]), .live_link_status(lnk),
		.rx_pkt_ok_i(ev[2]), .rx_pkt_abort_i(ev[3]), .wake_match_i(wm), .tx_request_bit(),
		.dma_start_bit(), .int_n, .wake_pin_n);
	initial forever #20 aclk = ~aclk;
	task chk(input [31:0] s, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				err_total = err_total + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		begin
			u_ecw_host.wr(a, v, r);
		end
	endtask
	task rc(input [7:0] a, input [31:0] m, input [31:0] e);
		begin
			u_ecw_host.rd(a, d, r);
			chk(d & m, e);
		end
	endtask
	// one-cycle event pulse, then room for flag and pin to follow
	task pls(input [4:0] v, input [7:0] m);
		begin
			@(posedge aclk);
			ev <= v;
			wm <= m;
			@(posedge aclk);
			ev <= 5'h00;
			wm <= 8'h00;
			repeat (4) @(posedge aclk);
		end
	endtask
	task pins(input ei, input ew);
		begin
			repeat (3) @(posedge aclk);
			chk({30'h0, int_n, wake_pin_n}, {30'h0, ei, ew});
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// a hang costs one mismatch and ends the run the normal way
	initial begin
		repeat (20000) @(posedge aclk);
		err_total = err_total + 1;
		finish_test;
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		for (i = 0; i <= 32; i = i + 4) begin
			rc(i[7:0], 32'hFFFFFFFF, 32'h0);
		end
		u_ecw_host.rd(8'h30, d, r);
		chk({30'h0, r}, 32'h2);
		wr(8'h30, 32'h0);
		chk({30'h0, r}, 32'h2);
		$display("test reset done");
		wr(CTL, 32'h08);
		pls(5'h01, 8'h00);
		rc(FLG, 32'hFF, 32'h08);
		pins(1'h1, 1'h1);
		wr(ENA, 32'h88);
		pins(1'h0, 1'h1);
		wr(ENA, 32'h08);
		pins(1'h1, 1'h1);
		rc(FLG, 32'hFF, 32'h08);
		wr(ENA, 32'h88);
		wr(FCL, 32'h08);
		pins(1'h1, 1'h1);
		wr(CTL, 32'h08);
		wr(CTL, 32'h00);
		rc(FLG, 32'hFF, 32'h08);
		wr(FCL, 32'h08);
		wr(CTL, 32'h08);
		pls(5'h10, 8'h00);
		rc(FLG, 32'hFF, 32'h08);
		rc(STA, 32'hFF, 32'h02);
		wr(STA, 32'h00);
		wr(FCL, 32'h08);
		$display("test transmit done");
		wr(ENA, 32'hA0);
		wr(CTL, 32'h20);
		pls(5'h02, 8'h00);
		rc(CTL, 32'hFF, 32'h00);
		rc(FLG, 32'hFF, 32'h20);
		pins(1'h0, 1'h1);
		wr(FCL, 32'h20);
		wr(CTL, 32'h20);
		wr(CTL, 32'h00);
		rc(FLG, 32'hFF, 32'h20);
		wr(FCL, 32'h20);
		pins(1'h1, 1'h1);
		$display("test dma done");
		wr(ENA, 32'h90);
		lnk <= 1'h1;
		pins(1'h1, 1'h1);
		rc(FLG, 32'hFF, 32'h00);
		u_ecw_host.rd(PRQ, d, r);
		wr(PEN, 32'h12);
		lnk <= 1'h0;
		pins(1'h0, 1'h1);
		rc(FLG, 32'hFF, 32'h10);
		wr(PEN, 32'h10);
		pins(1'h1, 1'h1);
		wr(PEN, 32'h12);
		wr(FCL, 32'h10);
		rc(FLG, 32'hFF, 32'h10);
		rc(PRQ, 32'hFF, 32'h14);
		rc(FLG, 32'hFF, 32'h00);
		pins(1'h1, 1'h1);
		$display("test link done");
		wr(ENA, 32'h00);
		pls(5'h04, 8'h00);
		pls(5'h04, 8'h00);
		rc(CNT, 32'hFF, 32'h02);
		rc(FLG, 32'hFF, 32'h40);
		wr(ENA, 32'hC0);
		pins(1'h0, 1'h1);
		wr(DEC, 32'h01);
		rc(FLG, 32'hFF, 32'h40);
		wr(DEC, 32'h01);
		rc(CNT, 32'hFF, 32'h00);
		pins(1'h1, 1'h1);
		$display("test packet done");
		// global irq enable stays off, so the wake pin stands on its own
		wr(ENA, 32'h04);
		for (i = 0; i < 8; i = i + 1) begin
			if (i != 5) begin
				wr(WEN, 32'h00);
				pls(5'h04, 8'h01 << i);
				rc(WRQ, 32'hFF, 32'h01 << i);
				rc(FLG, 32'h04, 32'h00);
				wr(WCL, 32'hFF);
				wr(WEN, 32'h01 << i);
				pls(5'h04, 8'h01 << i);
				rc(FLG, 32'h04, 32'h04);
				pins(1'h1, 1'h0);
				wr(WCL, 32'hFF);
				wr(FCL, 32'h04);
				pins(1'h1, 1'h1);
			end
		end
		wr(WEN, 32'hDF);
		pls(5'h0C, 8'h01);
		pls(5'h00, 8'h01);
		rc(WRQ, 32'hFF, 32'h00);
		pins(1'h1, 1'h1);
		$display("test wake done");
		// a reset in mid-run must clear a standing flag and the counter
		wr(CTL, 32'h08);
		wr(CTL, 32'h00);
		rc(FLG, 32'h08, 32'h08);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rc(FLG, 32'hFF, 32'h00);
		rc(CNT, 32'hFF, 32'h00);
		pins(1'h1, 1'h1);
		$display("test second reset done");
		finish_test;
	end
endmodule
